// ==== src/pss_pkg.sv ====
// Package: constants and types for the pulse/step output sequencer
package pss_pkg;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_US = 100;  // Duration unit: 0.1 ms
    localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
    // -----------------------------------------------------------------
    // Limits and reset values
    // -----------------------------------------------------------------
    localparam int REP_MAX = 999999;
    localparam logic [19:0] REP_MAX_W = 20'hf423f;
    localparam int DUR_MAX_TICKS = 129600000;  // 12960000 ms in 0.1 ms
    localparam logic [19:0] REP_ONE = 20'h00001;
    localparam logic [26:0] DUR_RESET = 27'h0000001;
    localparam logic [26:0] DUR_MAX_W = 27'h7b98a00;
    localparam logic [19:0] REP_RESET = 20'h00001;
    localparam logic [1:0] TRIG_SRC_SEQ = 2'h1;  // Sequencer trigger
    // -----------------------------------------------------------------
    // Sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSS_IDLE,
        PSS_WAIT,
        PSS_ACTIVE,
        PSS_INACTIVE
    } pss_state_t;
endpackage

// ==== src/pss_phase_timer.sv ====
// Phase timer: counts a duration in 0.1 ms ticks
`timescale 1ns/1ns
module pss_phase_timer
    import pss_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int DUR_W = 27
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic start_i,
    input wire logic [DUR_W-1:0] dur_i,
    // Status
    output logic done_o
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

    logic [PW-1:0] pre_r;
    logic [DUR_W-1:0] left_r;
    logic run_r;

    // Done is high in the last cycle, so the phase ends exactly on time
    assign done_o = run_r && (pre_r == PRE_LAST) && (left_r <= DUR_W'(1));

    // Prescaler and tick counter
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pre_r <= '0;
            left_r <= '0;
            run_r <= 1'b0;
        end else begin
            if (start_i) begin
                pre_r <= '0;
                left_r <= dur_i;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (pre_r == PRE_LAST) begin
                    pre_r <= '0;
                    if (left_r <= DUR_W'(1)) begin
                        run_r <= 1'b0;
                    end else begin
                        left_r <= left_r - DUR_W'(1);
                    end
                end else begin
                    pre_r <= pre_r + PW'(1);
                end
            end
        end
    end
endmodule

// ==== src/pss_sequencer.sv ====
// Pulse sequencer with step setpoint store and output select
`timescale 1ns/1ns
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int SP_W = 24,
    parameter int DUR_W = 27,
    parameter int TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Pulse configuration
    input wire logic cfg_we_i,
    input wire logic rep_infinite_i,
    input wire logic [19:0] rep_count_i,
    input wire logic [DUR_W-1:0] active_ticks_i,
    input wire logic [DUR_W-1:0] inactive_ticks_i,
    input wire logic [1:0] pulse_trigger_out_enables_i,
    input wire logic [1:0] trigger_out_source_select_i,
    // Pulse setpoints (amplitude, offset, frequency)
    input wire logic [SP_W-1:0] pulse_ac_i,
    input wire logic [SP_W-1:0] pulse_dc_i,
    input wire logic [SP_W-1:0] pulse_freq_i,
    // Step setpoint write
    input wire logic step_we_i,
    input wire logic [SP_W-1:0] step_ac_amplitude_i,
    input wire logic [SP_W-1:0] step_ac_rise_rate_i,
    input wire logic [SP_W-1:0] step_ac_fall_rate_i,
    input wire logic [SP_W-1:0] step_dc_offset_i,
    input wire logic [SP_W-1:0] step_dc_rise_rate_i,
    input wire logic [SP_W-1:0] step_dc_fall_rate_i,
    input wire logic [SP_W-1:0] step_freq_i,
    input wire logic [SP_W-1:0] step_freq_rise_rate_i,
    input wire logic ac_plus_dc_mode_i,
    // Sequencer commands
    input wire logic arm_i,
    input wire logic trigger_i,
    input wire logic abort_i,
    // Status
    output logic [1:0] state_o,
    output logic [19:0] rep_num_o,
    output logic cfg_err_o,
    output logic trigger_out_o,
    // Held step setpoints
    output logic [SP_W-1:0] step_ac_amplitude_o,
    output logic [SP_W-1:0] step_ac_rise_rate_o,
    output logic [SP_W-1:0] step_ac_fall_rate_o,
    output logic [SP_W-1:0] step_dc_offset_o,
    output logic [SP_W-1:0] step_dc_rise_rate_o,
    output logic [SP_W-1:0] step_dc_fall_rate_o,
    output logic [SP_W-1:0] step_freq_o,
    output logic [SP_W-1:0] step_freq_rise_rate_o,
    // Selected output setpoints
    output logic [SP_W-1:0] out_ac_o,
    output logic [SP_W-1:0] out_dc_o,
    output logic [SP_W-1:0] out_freq_o
);
    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic rep_inf_r;
    logic [19:0] rep_cnt_r;
    logic [DUR_W-1:0] act_dur_r;
    logic [DUR_W-1:0] inact_dur_r;
    logic [1:0] trig_en_r;
    logic [1:0] trig_src_r;
    pss_state_t state_r;
    pss_state_t state_nxt;

    // Range check of a duration in ticks
    function automatic logic dur_ok(input logic [DUR_W-1:0] d);
        dur_ok = (d != '0) && (d <= DUR_W'(DUR_MAX_W));
    endfunction

    logic cfg_ok;
    assign cfg_ok = (rep_infinite_i || ((rep_count_i != '0) &&
                     (rep_count_i <= REP_MAX_W))) &&
                    dur_ok(active_ticks_i) &&
                    dur_ok(inactive_ticks_i);

    // Accept counts and durations only while idle and in range; trigger enables and source on every write
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rep_inf_r <= 1'b0;
            rep_cnt_r <= REP_RESET;
            act_dur_r <= DUR_W'(DUR_RESET);
            inact_dur_r <= DUR_W'(DUR_RESET);
            trig_en_r <= 2'h0;
            trig_src_r <= 2'h0;
            cfg_err_o <= 1'b0;
        end else if (cfg_we_i) begin
            trig_en_r <= pulse_trigger_out_enables_i;
            trig_src_r <= trigger_out_source_select_i;
            if (cfg_ok && state_r == PSS_IDLE) begin
                rep_inf_r <= rep_infinite_i;
                rep_cnt_r <= rep_count_i;
                act_dur_r <= active_ticks_i;
                inact_dur_r <= inactive_ticks_i;
                cfg_err_o <= 1'b0;
            end else begin
                cfg_err_o <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Step setpoint store
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            step_ac_amplitude_o <= '0;
            step_ac_rise_rate_o <= '0;
            step_ac_fall_rate_o <= '0;
            step_dc_offset_o <= '0;
            step_dc_rise_rate_o <= '0;
            step_dc_fall_rate_o <= '0;
            step_freq_o <= '0;
            step_freq_rise_rate_o <= '0;
        end else if (step_we_i) begin
            step_ac_amplitude_o <= step_ac_amplitude_i;
            step_ac_rise_rate_o <= step_ac_rise_rate_i;
            step_ac_fall_rate_o <= step_ac_fall_rate_i;
            step_dc_offset_o <= step_dc_offset_i;
            step_dc_rise_rate_o <= step_dc_rise_rate_i;
            step_dc_fall_rate_o <= step_dc_fall_rate_i;
            step_freq_o <= step_freq_i;
            step_freq_rise_rate_o <= step_freq_rise_rate_i;
        end
    end

    // -----------------------------------------------------------------
    // Phase timer
    // -----------------------------------------------------------------
    logic tmr_start;
    logic tmr_done;
    logic [DUR_W-1:0] tmr_dur;

    assign tmr_start = (state_nxt != state_r) &&
                       (state_nxt == PSS_ACTIVE ||
                        state_nxt == PSS_INACTIVE);
    assign tmr_dur = (state_nxt == PSS_ACTIVE) ? act_dur_r : inact_dur_r;

    pss_phase_timer #(
        .TICK_CYC(TICK_CYC),
        .DUR_W(DUR_W)
    ) u_timer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .start_i(tmr_start),
        .dur_i(tmr_dur),
        .done_o(tmr_done)
    );

    // -----------------------------------------------------------------
    // Sequencer state machine
    // -----------------------------------------------------------------
    logic [19:0] rep_r;
    logic last_rep;

    // Last pass reached unless infinite mode is set
    assign last_rep = !rep_inf_r && (rep_r >= rep_cnt_r);

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        if (abort_i) begin
            state_nxt = PSS_IDLE;
        end else begin
            unique case (state_r)
                PSS_IDLE: begin
                    if (arm_i) begin
                        state_nxt = PSS_WAIT;
                    end
                end
                PSS_WAIT: begin
                    if (trigger_i) begin
                        state_nxt = PSS_ACTIVE;
                    end
                end
                PSS_ACTIVE: begin
                    if (tmr_done) begin
                        state_nxt = last_rep ? PSS_IDLE : PSS_INACTIVE;
                    end
                end
                PSS_INACTIVE: begin
                    if (tmr_done) begin
                        state_nxt = PSS_ACTIVE;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r <= PSS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Repetition counter, one-based, held at one outside running
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rep_r <= REP_ONE;
        end else if (state_nxt == PSS_IDLE || state_nxt == PSS_WAIT) begin
            rep_r <= REP_ONE;
        end else if (state_r == PSS_INACTIVE &&
                     state_nxt == PSS_ACTIVE) begin
            // Saturate in infinite mode to keep the count in range
            if (rep_r != REP_MAX_W) begin
                rep_r <= rep_r + 20'h00001;
            end
        end
    end

    // -----------------------------------------------------------------
    // Status and trigger-out
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_o <= 2'h0;
            rep_num_o <= REP_ONE;
        end else begin
            state_o <= state_nxt;
            if (state_nxt == PSS_ACTIVE || state_nxt == PSS_INACTIVE) begin
                rep_num_o <= (state_r == PSS_INACTIVE &&
                              state_nxt == PSS_ACTIVE &&
                              rep_r != REP_MAX_W) ?
                             rep_r + 20'h00001 : rep_r;
            end else begin
                rep_num_o <= REP_ONE;
            end
        end
    end

    // One-cycle trigger pulse on entry to an enabled phase while the sequencer source is selected
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            trigger_out_o <= 1'b0;
        end else begin
            trigger_out_o <= (trig_src_r == TRIG_SRC_SEQ) &&
                             (state_nxt != state_r) &&
                             ((state_nxt == PSS_ACTIVE && trig_en_r[0]) ||
                              (state_nxt == PSS_INACTIVE &&
                               trig_en_r[1]));
        end
    end

    // -----------------------------------------------------------------
    // Output setpoint select
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            out_ac_o <= '0;
            out_dc_o <= '0;
            out_freq_o <= '0;
        end else if (state_nxt == PSS_ACTIVE) begin
            out_ac_o <= pulse_ac_i;
            out_dc_o <= ac_plus_dc_mode_i ? pulse_dc_i : '0;
            out_freq_o <= pulse_freq_i;
        end else begin
            out_ac_o <= step_ac_amplitude_o;
            out_dc_o <= ac_plus_dc_mode_i ? step_dc_offset_o : '0;
            out_freq_o <= step_freq_o;
        end
    end
endmodule

// ==== verif/pss_sequencer_assertions.sv ====
// Checker: port-level properties of the pulse/step sequencer
`timescale 1ns/1ns
module pss_sequencer_assertions
    import pss_pkg::*;
#(
    parameter int SP_W = 24
) (
    // Clock, reset and commands
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic trigger_i,
    input wire logic abort_i,
    input wire logic step_we_i,
    // Configuration and setpoints
    input wire logic [1:0] pulse_trigger_out_enables_i,
    input wire logic [1:0] trigger_out_source_select_i,
    input wire logic [SP_W-1:0] pulse_ac_i,
    input wire logic [SP_W-1:0] step_ac_amplitude_i,
    input wire logic [SP_W-1:0] step_ac_rise_rate_i,
    // Observed outputs
    input wire logic [1:0] state_o,
    input wire logic [19:0] rep_num_o,
    input wire logic trigger_out_o,
    input wire logic [SP_W-1:0] step_ac_amplitude_o,
    input wire logic [SP_W-1:0] step_ac_rise_rate_o,
    input wire logic [SP_W-1:0] out_ac_o
);
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_idle_rep_one: assert property (state_o[1] == 1'b0 |->
        rep_num_o == REP_ONE) else $error("rep not one when idle");
    a_rep_range: assert property (rep_num_o <= REP_MAX_W)
        else $error("rep above limit");
    a_trig_single: assert property (trigger_out_o |=> !trigger_out_o)
        else $error("trigger longer than one cycle");
    a_trig_change: assert property (trigger_out_o |-> $changed(state_o))
        else $error("trigger without state change");
    a_trig_source: assert property (trigger_out_o |->
        $past(trigger_out_source_select_i) == TRIG_SRC_SEQ)
        else $error("trigger with other source");
    a_trig_enable: assert property (trigger_out_o |->
        state_o == PSS_ACTIVE && $past(pulse_trigger_out_enables_i[0]) ||
        state_o == PSS_INACTIVE && $past(pulse_trigger_out_enables_i[1]))
        else $error("trigger while disabled");
    a_active_out: assert property (state_o == PSS_ACTIVE |->
        out_ac_o == pulse_ac_i) else $error("active output wrong");
    a_inactive_out: assert property (state_o == PSS_INACTIVE |->
        out_ac_o == step_ac_amplitude_o) else $error("inactive output wrong");
    a_rep_advance: assert property (state_o == PSS_ACTIVE &&
        $past(state_o) == PSS_INACTIVE |-> rep_num_o == $past(rep_num_o) + 20'h1)
        else $error("rep not advanced");
    a_wait_start: assert property (state_o == PSS_WAIT && trigger_i &&
        !abort_i |=> state_o == PSS_ACTIVE) else $error("trigger not taken");
    a_abort_idle: assert property (abort_i |=> state_o == PSS_IDLE)
        else $error("abort not idle");
    a_step_store: assert property (step_we_i |=>
        step_ac_amplitude_o == $past(step_ac_amplitude_i) &&
        step_ac_rise_rate_o == $past(step_ac_rise_rate_i))
        else $error("step setpoint not stored");
endmodule

// ==== verif/pss_sequencer_test.sv ====
// Testbench: command sequences for the pulse/step sequencer
`timescale 1ns/1ns
module pss_sequencer_test
    import pss_pkg::*;
;
    localparam int TK = 2;
    logic clk_i, reset_n_i, cfg_we_i, rep_infinite_i, step_we_i;
    logic ac_plus_dc_mode_i, arm_i, trigger_i, abort_i, cfg_err_o;
    logic trigger_out_o;
    logic [19:0] rep_count_i, rep_num_o;
    logic [26:0] active_ticks_i, inactive_ticks_i;
    logic [1:0] pulse_trigger_out_enables_i, trigger_out_source_select_i;
    logic [1:0] state_o;
    logic [23:0] pulse_ac_i, pulse_dc_i, pulse_freq_i, out_ac_o, out_dc_o;
    logic [23:0] out_freq_o;
    logic [23:0] sv [8];
    logic [23:0] so [8];
    logic [1:0] te [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h3};
    logic [1:0] ts [5] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2};
    int tt [5] = '{2, 1, 0, 0, 0};
    int err_count = 0, num_checks = 0, tcnt = 0, acnt = 0, icnt = 0;

    // Device under test with a short tick
    pss_sequencer #(.TICK_CYC(TK)) dut (
        .clk_i, .reset_n_i, .cfg_we_i, .rep_infinite_i, .rep_count_i,
        .active_ticks_i, .inactive_ticks_i, .pulse_trigger_out_enables_i,
        .trigger_out_source_select_i, .pulse_ac_i, .pulse_dc_i,
        .pulse_freq_i, .step_we_i, .step_ac_amplitude_i(sv[0]),
        .step_ac_rise_rate_i(sv[1]), .step_ac_fall_rate_i(sv[2]),
        .step_dc_offset_i(sv[3]), .step_dc_rise_rate_i(sv[4]),
        .step_dc_fall_rate_i(sv[5]), .step_freq_i(sv[6]),
        .step_freq_rise_rate_i(sv[7]), .ac_plus_dc_mode_i, .arm_i,
        .trigger_i, .abort_i, .state_o, .rep_num_o, .cfg_err_o,
        .trigger_out_o, .step_ac_amplitude_o(so[0]),
        .step_ac_rise_rate_o(so[1]), .step_ac_fall_rate_o(so[2]),
        .step_dc_offset_o(so[3]), .step_dc_rise_rate_o(so[4]),
        .step_dc_fall_rate_o(so[5]), .step_freq_o(so[6]),
        .step_freq_rise_rate_o(so[7]), .out_ac_o, .out_dc_o, .out_freq_o
    );

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic pls(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic wst(input logic [1:0] s);
        for (int i = 0; i < 200 && state_o !== s; i++) cyc(1);
        chk("state", 24'(state_o), 24'(s));
    endtask
    task automatic cfg(input logic [19:0] c, input logic [26:0] a, n,
                       input logic [1:0] e, s, input logic x);
        rep_count_i = c;
        active_ticks_i = a;
        inactive_ticks_i = n;
        pulse_trigger_out_enables_i = e;
        trigger_out_source_select_i = s;
        pls(cfg_we_i);
        chk("cfg_err", 24'(cfg_err_o), 24'(x));
    endtask
    // Full run: arm, trigger, walk every repetition back to idle
    task automatic run(input int n, act, ina, ntr);
        tcnt = 0;
        acnt = 0;
        icnt = 0;
        pls(arm_i);
        wst(PSS_WAIT);
        chk("rep", 24'(rep_num_o), 24'h1);
        pls(trigger_i);
        for (int r = 1; r <= n; r++) begin
            wst(PSS_ACTIVE);
            chk("rep", 24'(rep_num_o), 24'(r));
            chk("ac", out_ac_o, pulse_ac_i);
            chk("fq", out_freq_o, pulse_freq_i);
            chk("dc", out_dc_o, ac_plus_dc_mode_i ? pulse_dc_i : 24'h0);
            if (r < n) begin
                wst(PSS_INACTIVE);
                chk("iac", out_ac_o, sv[0]);
                chk("ifq", out_freq_o, sv[6]);
                chk("idc", out_dc_o, ac_plus_dc_mode_i ? sv[3] : 24'h0);
            end
        end
        wst(PSS_IDLE);
        chk("rep", 24'(rep_num_o), 24'h1);
        chk("trig", 24'(tcnt), 24'(ntr));
        chk("actlen", 24'(acnt), 24'(n * act * TK));
        chk("inalen", 24'(icnt), 24'((n - 1) * ina * TK));
    endtask

    // -----------------------------------------------------------------
    // Clock, monitors and watchdog
    // -----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (trigger_out_o === 1'b1) tcnt++;
        if (state_o === PSS_ACTIVE) acnt++;
        if (state_o === PSS_INACTIVE) icnt++;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        complete_run();
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {reset_n_i, cfg_we_i, rep_infinite_i, step_we_i} = 4'h0;
        {ac_plus_dc_mode_i, arm_i, trigger_i, abort_i} = 4'h0;
        rep_count_i = 20'h1;
        {active_ticks_i, inactive_ticks_i} = {27'h1, 27'h1};
        pulse_trigger_out_enables_i = 2'h0;
        trigger_out_source_select_i = 2'h0;
        {pulse_ac_i, pulse_dc_i, pulse_freq_i} = {24'ha1, 24'hb2, 24'hc3};
        for (int i = 0; i < 8; i++) sv[i] = 24'h10 + 24'(i);
        cyc(16);
        reset_n_i = 1'b1;
        cyc(1);
        chk("state", 24'(state_o), 24'h0);
        chk("rep", 24'(rep_num_o), 24'h1);
        pls(step_we_i);
        for (int i = 0; i < 8; i++) chk("step", so[i], sv[i]);
        cfg(20'h0, 27'h1, 27'h1, 2'h0, 2'h0, 1'b1);
        cfg(20'hf4240, 27'h1, 27'h1, 2'h0, 2'h0, 1'b1);
        cfg(REP_MAX_W, 27'h1, 27'h1, 2'h0, 2'h0, 1'b0);
        cfg(20'h1, 27'h0, 27'h1, 2'h0, 2'h0, 1'b1);
        cfg(20'h1, DUR_MAX_W + 27'h1, 27'h1, 2'h0, 2'h0, 1'b1);
        cfg(20'h1, DUR_MAX_W, DUR_MAX_W + 27'h1, 2'h0, 2'h0, 1'b1);
        cfg(20'h1, DUR_MAX_W, DUR_MAX_W, 2'h0, 2'h0, 1'b0);
        cfg(20'h3, 27'h2, 27'h3, 2'h0, 2'h0, 1'b0);
        cfg(20'h0, 27'h1, 27'h1, 2'h3, 2'h1, 1'b1);
        run(3, 2, 3, 5);
        ac_plus_dc_mode_i = 1'b1;
        for (int k = 0; k < 5; k++) begin
            cfg(20'h2, 27'h1, 27'h1, te[k], ts[k], 1'b0);
            run(2, 1, 1, tt[k]);
        end
        rep_infinite_i = 1'b1;
        cfg(20'h1, 27'h1, 27'h1, 2'h0, 2'h1, 1'b0);
        pls(arm_i);
        pls(trigger_i);
        for (int i = 0; i < 300 && rep_num_o !== 20'h4; i++) cyc(1);
        chk("rep", 24'(rep_num_o), 24'h4);
        chk("running", 24'(state_o[1]), 24'h1);
        cfg(20'h2, 27'h1, 27'h1, 2'h0, 2'h1, 1'b1);
        pls(abort_i);
        chk("state", 24'(state_o), 24'h0);
        chk("rep", 24'(rep_num_o), 24'h1);
        complete_run();
    end
endmodule

bind pss_sequencer pss_sequencer_assertions #(.SP_W(SP_W)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .trigger_i(trigger_i),
    .abort_i(abort_i), .step_we_i(step_we_i),
    .pulse_trigger_out_enables_i(pulse_trigger_out_enables_i),
    .trigger_out_source_select_i(trigger_out_source_select_i),
    .pulse_ac_i(pulse_ac_i), .step_ac_amplitude_i(step_ac_amplitude_i),
    .step_ac_rise_rate_i(step_ac_rise_rate_i), .state_o(state_o),
    .rep_num_o(rep_num_o), .trigger_out_o(trigger_out_o),
    .step_ac_amplitude_o(step_ac_amplitude_o),
    .step_ac_rise_rate_o(step_ac_rise_rate_o), .out_ac_o(out_ac_o)
);
